/* rtl/spectral_alarm_pkg.sv */
// Shared constants and carriers of the spectral alarm register bank
package spectral_alarm_pkg;
	// ==============================
	// Register byte offsets
	localparam logic [7:0] ADDR_WARN_X = 8'h24;
	localparam logic [7:0] ADDR_WARN_Y = 8'h26;
	localparam logic [7:0] ADDR_CRIT_X = 8'h28;
	localparam logic [7:0] ADDR_CRIT_Y = 8'h2A;
	localparam logic [7:0] ADDR_SYS_THR = 8'h2E;
	localparam logic [7:0] ADDR_CTL = 8'h30;
	localparam logic [7:0] ADDR_DIAG = 8'h34;
	localparam logic [7:0] ADDR_CMD = 8'h36;
	localparam logic [7:0] ADDR_STAT_X = 8'h38;
	localparam logic [7:0] ADDR_STAT_Y = 8'h3A;
	localparam logic [7:0] ADDR_PEAK_X = 8'h3C;
	localparam logic [7:0] ADDR_PEAK_Y = 8'h3E;
	localparam logic [7:0] ADDR_BIN_X = 8'h44;
	localparam logic [7:0] ADDR_BIN_Y = 8'h46;
	localparam logic [7:0] ADDR_GPO = 8'h48;
	// ==============================
	// Reset values
	localparam logic [15:0] CTL_RESET = 16'h0080;
	localparam logic [15:0] ZERO16 = 16'h0000;
	// ==============================
	// Field positions
	localparam int CTL_S_EN = 3;
	localparam int CTL_S_SRC = 4;
	localparam int CTL_S_POL = 5;
	localparam int CTL_DO_EN = 6;
	localparam int CTL_LATCH = 7;
	localparam int CTL_DLY = 8;
	localparam int CMD_CLR_STAT = 4;
	localparam int CMD_CLEAR = 9;
	localparam int CMD_SAVE = 12;
	localparam int DIAG_SYS = 0;
	localparam int DIAG_REJ = 1;
	localparam int DIAG_SPEC = 2;
	localparam int NBANDS = 6;
	localparam logic [2:0] FN_ALARM = 3'h1;
	localparam logic [4:0] CNT_MAX = 5'h10;
	// ==============================
	// Carriers
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} host_req_t;
	typedef struct packed {
		logic valid;
		logic [1:0][5:0][15:0] mag;
		logic [1:0][5:0][7:0] bin;
		logic [15:0] temp;
		logic [15:0] supply;
	} record_t;
	typedef struct packed {
		logic [1:0][15:0] warn;
		logic [1:0][15:0] crit;
		logic [15:0] sys_thr;
		logic [15:0] ctl;
		logic [5:0] gpo;
		logic [1:0][15:0] stat;
		logic [1:0][15:0] peak;
		logic [1:0][7:0] bin;
		logic [2:0] diag;
		logic saved;
		logic [23:0][4:0] cnt;
		logic [15:0] rdata;
		logic do1;
		logic do2;
	} state_t;
endpackage

/* rtl/spectral_alarm_regs.sv */
// Spectral alarm register bank with band evaluation and alarm pins
// What this block does
// - X critical threshold, RW, resets zero
// - Y critical threshold, RW, resets zero
// - System threshold compares chosen measurement
// - Save ignored once storage already written
// - Output function selected by low six bits
// - Output one warning, output two critical
// - Diagnostic, band flags, peak and bin kept
// - Band status covers current rate only
// - Band n: bit 2n+3 critical, 2n+2 warning
// - Band one warning bit 4, bit 3 zero
// - Bits 2:0 hold most critical band
// - Per-axis worst peak magnitude readable
// - Per-axis worst FFT bin readable
// - Source: 1 temperature; polarity 1 less-than
// - Flag sets after response delay records
// - Output enable bit routes alarms to pins
module spectral_alarm_regs (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire spectral_alarm_pkg::host_req_t host,
	output logic [15:0] rd_data,
	input wire spectral_alarm_pkg::record_t rec,
	output logic digital_output_one,
	output logic digital_output_two
);
	import spectral_alarm_pkg::*;

	// ==============================
	// State
	state_t q; // Registered state
	state_t d; // Next state
	logic [2:0] ev; // Diagnostic events
	logic [2:0] upd; // Diagnostic bits refreshed
	logic [15:0] thr; // Threshold under test
	logic [4:0] cn; // Next persistence count
	logic [4:0] idx; // Counter index
	logic cond; // Level exceeded
	logic flag; // Persistent alarm
	logic [2:0] best; // Worst band number
	logic [1:0] blvl; // Worst level seen
	logic [15:0] bmag; // Worst band magnitude
	logic [7:0] bbin; // Worst band bin
	logic [15:0] mmag; // Strongest content
	logic [7:0] mbin; // Strongest content bin
	logic [15:0] sval; // System measurement
	logic strig; // System alarm hit
	logic anyw; // Any warning flag
	logic anyc; // Any critical flag

	// ==============================
	// Next-state logic
	always_comb begin
		d = q;
		ev = '0;
		upd = '0;
		thr = '0;
		cn = '0;
		idx = '0;
		cond = 1'b0;
		flag = 1'b0;
		best = '0;
		blvl = '0;
		bmag = '0;
		bbin = '0;
		mmag = '0;
		mbin = '0;
		sval = '0;
		strig = 1'b0;
		anyw = 1'b0;
		anyc = 1'b0;
		d.rdata = '0;
		// Read mux, answer next cycle
		if (host.rd) begin
			case (host.addr)
				ADDR_WARN_X: d.rdata = q.warn[0];
				ADDR_WARN_Y: d.rdata = q.warn[1];
				ADDR_CRIT_X: d.rdata = q.crit[0];
				ADDR_CRIT_Y: d.rdata = q.crit[1];
				ADDR_SYS_THR: d.rdata = q.sys_thr;
				ADDR_CTL: d.rdata = q.ctl;
				ADDR_DIAG: d.rdata = {13'h0000, q.diag};
				ADDR_STAT_X: d.rdata = q.stat[0];
				ADDR_STAT_Y: d.rdata = q.stat[1];
				ADDR_PEAK_X: d.rdata = q.peak[0];
				ADDR_PEAK_Y: d.rdata = q.peak[1];
				ADDR_BIN_X: d.rdata = {8'h00, q.bin[0]};
				ADDR_BIN_Y: d.rdata = {8'h00, q.bin[1]};
				ADDR_GPO: d.rdata = {10'h000, q.gpo};
				default: d.rdata = '0;
			endcase
		end
		// Register writes
		if (host.wr) begin
			case (host.addr)
				ADDR_WARN_X: d.warn[0] = host.wdata;
				ADDR_WARN_Y: d.warn[1] = host.wdata;
				ADDR_CRIT_X: d.crit[0] = host.wdata;
				ADDR_CRIT_Y: d.crit[1] = host.wdata;
				ADDR_SYS_THR: d.sys_thr = host.wdata;
				ADDR_CTL: d.ctl = {4'h0, host.wdata[11:0]};
				ADDR_GPO: d.gpo = host.wdata[5:0];
				ADDR_CMD: begin
					if (host.wdata[CMD_CLEAR]) begin
						d.warn = '0;
						d.crit = '0;
						d.saved = 1'b0;
					end else if (host.wdata[CMD_SAVE]) begin
						if (q.saved) begin
							ev[DIAG_REJ] = 1'b1;
						end else begin
							d.saved = 1'b1;
						end
						upd[DIAG_REJ] = 1'b1;
					end
				end
				default: begin
					// Read-only or unmapped: ignored
				end
			endcase
		end
		if (rec.valid) begin
			for (int a = 0; a < 2; a++) begin
				best = '0;
				blvl = '0;
				bmag = '0;
				bbin = '0;
				mmag = '0;
				mbin = '0;
				d.stat[a] = '0;
				for (int n = 0; n < NBANDS; n++) begin
					if (rec.mag[a][n] >= mmag) begin
						mmag = rec.mag[a][n];
						mbin = rec.bin[a][n];
					end
					for (int l = 0; l < 2; l++) begin
						thr = (l == 1) ? q.crit[a] : q.warn[a];
						cond = q.ctl[a] && (rec.mag[a][n] > thr);
						idx = 5'(a * 12 + n * 2 + l);
						if (!cond) begin
							cn = '0;
						end else if (q.cnt[idx] == CNT_MAX) begin
							cn = CNT_MAX;
						end else begin
							cn = q.cnt[idx] + 5'h01;
						end
						d.cnt[idx] = cn;
						flag = cond && (cn > {1'b0, q.ctl[CTL_DLY+:4]});
						// Band one from bit 4
						// Bits 3:0 belong to band number and spare bit
						d.stat[a][2*n+4+l] = flag;
						if (flag && (2'(l + 1) > blvl
								|| (2'(l + 1) == blvl && rec.mag[a][n] > bmag))) begin
							blvl = 2'(l + 1);
							best = 3'(n + 1);
							bmag = rec.mag[a][n];
							bbin = rec.bin[a][n];
						end
					end
				end
				d.stat[a][2:0] = best;
				d.peak[a] = (best != 3'h0) ? bmag : mmag;
				d.bin[a] = (best != 3'h0) ? bbin : mbin;
				anyw = anyw | (|d.stat[a][15:4]);
			end
			sval = q.ctl[CTL_S_SRC] ? rec.temp : rec.supply;
			strig = q.ctl[CTL_S_POL] ? (sval < q.sys_thr) : (sval > q.sys_thr);
			ev[DIAG_SYS] = q.ctl[CTL_S_EN] && strig;
			ev[DIAG_SPEC] = anyw;
			upd[DIAG_SYS] = 1'b1;
			upd[DIAG_SPEC] = 1'b1;
		end
		// Diagnostic flags: set wins over clear
		if (host.wr && host.addr == ADDR_CMD && host.wdata[CMD_CLR_STAT]) begin
			d.diag = ev;
		end else if (q.ctl[CTL_LATCH]) begin
			d.diag = q.diag | ev;
		end else begin
			d.diag = (q.diag & ~upd) | ev;
		end
		// Any level flag on either axis
		anyw = 1'b0;
		anyc = 1'b0;
		for (int a = 0; a < 2; a++) begin
			for (int n = 0; n < NBANDS; n++) begin
				anyw = anyw | q.stat[a][2*n+4];
				anyc = anyc | q.stat[a][2*n+5];
			end
		end
		// Warning to one, critical to two
		d.do1 = q.ctl[CTL_DO_EN] && (q.gpo[2:0] == FN_ALARM) && anyw;
		d.do2 = q.ctl[CTL_DO_EN] && (q.gpo[5:3] == FN_ALARM) && anyc;
	end

	// ==============================
	// State register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
			q.ctl <= CTL_RESET;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from flops
	assign rd_data = q.rdata;
	assign digital_output_one = q.do1;
	assign digital_output_two = q.do2;

	// ==============================
	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	crit_x_store_a: assert property (host.wr && host.addr == ADDR_CRIT_X
		|=> q.crit[0] == $past(host.wdata)) else $error("crit x not stored");
	crit_x_read_a: assert property (host.rd && host.addr == ADDR_CRIT_X
		|=> rd_data == $past(q.crit[0])) else $error("crit x readback wrong");
	crit_y_store_a: assert property (host.wr && host.addr == ADDR_CRIT_Y
		|=> q.crit[1] == $past(host.wdata)) else $error("crit y not stored");
	clear_cmd_a: assert property (host.wr && host.addr == ADDR_CMD
		&& host.wdata[CMD_CLEAR]
		|=> q.crit == '0 && q.warn == '0 && !q.saved) else $error("clear failed");
	save_commit_a: assert property (host.wr && host.addr == ADDR_CMD
		&& host.wdata[CMD_SAVE] && !host.wdata[CMD_CLEAR] && !q.saved
		|=> q.saved) else $error("save not taken");
	save_reject_a: assert property (host.wr && host.addr == ADDR_CMD
		&& host.wdata[CMD_SAVE] && !host.wdata[CMD_CLEAR] && q.saved
		|=> q.diag[DIAG_REJ] && q.saved) else $error("save not rejected");
	diag_clear_a: assert property (host.wr && host.addr == ADDR_CMD
		&& host.wdata[CMD_CLR_STAT] && !host.wdata[CMD_SAVE] && !rec.valid
		|=> q.diag == '0) else $error("diagnostic flags not cleared");
	stat_ro_a: assert property (host.wr && host.addr == ADDR_STAT_X && !rec.valid
		|=> q.stat[0] == $past(q.stat[0])) else $error("status written by host");
	axis_off_a: assert property (rec.valid && !q.ctl[0]
		|=> q.stat[0][15:3] == '0) else $error("flags on disabled axis");
	unused_bit_a: assert property (!q.stat[0][3] && !q.stat[1][3])
		else $error("status bit three set");
	band_range_a: assert property (q.stat[0][2:0] <= 3'h6
		&& q.stat[1][2:0] <= 3'h6) else $error("band number out of range");
	delay_hold_a: assert property (rec.valid && q.ctl[CTL_DLY+:4] != 4'h0
		&& q.cnt[0] == 5'h00 |=> !q.stat[0][4]) else $error("flag before delay");
	sys_alarm_a: assert property (rec.valid && q.ctl[CTL_S_EN]
		&& !q.ctl[CTL_S_SRC] && !q.ctl[CTL_S_POL] && rec.supply > q.sys_thr
		|=> q.diag[DIAG_SYS]) else $error("system alarm missed");
	pin_off_a: assert property (!q.ctl[CTL_DO_EN]
		|=> !digital_output_one && !digital_output_two) else $error("pin active");
	warn_pin_a: assert property (q.ctl[CTL_DO_EN] && q.gpo[2:0] == FN_ALARM
		&& q.stat[0][4] |=> digital_output_one) else $error("pin one missed warning");
	crit_pin_a: assert property (q.ctl[CTL_DO_EN] && q.gpo[5:3] == FN_ALARM
		&& q.stat[0][7] |=> digital_output_two) else $error("pin two missed critical");
	quiet_record_a: assert property (rec.valid && rec.mag[0] == '0
		|=> q.stat[0] == '0 && q.peak[0] == '0 && q.bin[0] == $past(rec.bin[0][5]))
		else $error("record set inconsistent");
	// Idle bus reads zero
	rdata_idle_a: assert property (!host.rd |=> rd_data == '0)
		else $error("read data without read");
endmodule // spectral_alarm_regs

/* verif/host_model.sv */
// Host processor model driving the register port of the alarm bank
module host_model (
	input wire logic sys_clk,
	output spectral_alarm_pkg::host_req_t host,
	input wire logic [15:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	import spectral_alarm_pkg::*;

	// ==============================
	// Idle bus from time zero
	initial begin
		host = '0;
	end

	// One-cycle write strobe, released after the taking edge
	task automatic wr(input logic [7:0] a, input logic [15:0] w);
		@(posedge sys_clk);
		host <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		host <= '0;
	endtask

	// One-cycle read strobe; data stands only in the following cycle
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		host <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		host <= '0;
		#1;
		d = rd_data;
	endtask
endmodule // host_model

/* verif/tb_spectral_alarm_regs.sv */
// Self-checking bench of the spectral alarm register bank
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_spectral_alarm_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import spectral_alarm_pkg::*;

	// ==============================
	// Signals and counters
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	host_req_t host;
	logic [15:0] rd_data;
	record_t rec;
	logic do1;
	logic do2;
	logic [15:0] d;
	int num_errors = 0;
	int check_count = 0;
	logic [15:0] sys_tab [3][2];

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	spectral_alarm_regs i_spectral_alarm_regs (.sys_clk(sys_clk), .reset_n(reset_n),
		.host(host), .rd_data(rd_data), .rec(rec), .digital_output_one(do1),
		.digital_output_two(do2));
	host_model i_host_model (.sys_clk(sys_clk), .host(host), .rd_data(rd_data));

	// Verdict and end of run
	task automatic finish_test;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Read a register and compare
	task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
		i_host_model.rd(a, d);
		`CHK(d, e)
	endtask

	// One x-axis record, returns once the pins have followed
	task automatic send(input logic [5:0][15:0] m);
		@(posedge sys_clk);
		rec.valid <= 1'b1;
		rec.mag[0] <= m;
		@(posedge sys_clk);
		rec.valid <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask

	// Hang guard
	initial begin
		#100us;
		num_errors++;
		finish_test();
	end

	// ==============================
	// Main sequence
	initial begin
		rec = '0;
		for (int n = 0; n < 6; n++) begin
			rec.bin[0][n] = 8'h10 + 8'(n);
			rec.bin[1][n] = 8'h20 + 8'(n);
		end
		rec.temp = 16'h2000;
		rec.supply = 16'h0500;
		sys_tab = '{'{16'h0018, 16'h0001}, '{16'h0038, 16'h0000}, '{16'h0028, 16'h0001}};
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		// Reset values
		chk_rd(8'h28, 16'h0000);
		chk_rd(8'h2A, 16'h0000);
		chk_rd(8'h38, 16'h0000);
		chk_rd(8'h3C, 16'h0000);
		chk_rd(8'h30, 16'h0080);
		i_host_model.wr(8'h2A, 16'h1234);
		chk_rd(8'h2A, 16'h1234);
		i_host_model.wr(8'h2E, 16'hA5A5);
		chk_rd(8'h2E, 16'hA5A5);
		// Read-only and unmapped places
		i_host_model.wr(8'h38, 16'hFFFF);
		chk_rd(8'h38, 16'h0000);
		chk_rd(8'h50, 16'h0000);
		// Clear, program, save twice
		i_host_model.wr(8'h28, 16'h7777);
		i_host_model.wr(8'h36, 16'h0200);
		chk_rd(8'h28, 16'h0000);
		i_host_model.wr(8'h24, 16'h0100);
		i_host_model.wr(8'h28, 16'h0200);
		i_host_model.wr(8'h36, 16'h1000);
		i_host_model.rd(8'h34, d);
		`CHK(d[1], 1'b0)
		i_host_model.wr(8'h36, 16'h1000);
		i_host_model.rd(8'h34, d);
		`CHK(d[1], 1'b1)
		// Pins routed, x enabled, no delay
		i_host_model.wr(8'h48, 16'h0009);
		i_host_model.wr(8'h30, 16'h0041);
		send({16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0300, 16'h0150});
		`CHK({do1, do2}, 2'b11)
		chk_rd(8'h38, 16'h00D2);
		chk_rd(8'h3A, 16'h0000);
		chk_rd(8'h3C, 16'h0300);
		chk_rd(8'h44, 16'h0011);
		send({16'h0300, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000});
		chk_rd(8'h38, 16'hC006);
		chk_rd(8'h44, 16'h0015);
		send({16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0150});
		`CHK({do1, do2}, 2'b10)
		chk_rd(8'h38, 16'h0011);
		// Function code cleared keeps pins low
		i_host_model.wr(8'h48, 16'h0000);
		send({16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0150});
		`CHK({do1, do2}, 2'b00)
		// Response delay of two records
		i_host_model.wr(8'h30, 16'h0241);
		send('0);
		for (int i = 0; i < 3; i++) begin
			send({16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0150});
			chk_rd(8'h38, (i < 2) ? 16'h0000 : 16'h0011);
		end
		// System alarm source and polarity
		i_host_model.wr(8'h2E, 16'h1000);
		for (int i = 0; i < 3; i++) begin
			i_host_model.wr(8'h30, sys_tab[i][0]);
			send('0);
			i_host_model.rd(8'h34, d);
			`CHK(d[0], sys_tab[i][1][0])
		end
		// Y axis alone, band 3 critical and band 5 warning
		i_host_model.wr(8'h26, 16'h0100);
		i_host_model.wr(8'h2A, 16'h0400);
		i_host_model.wr(8'h30, 16'h0002);
		rec.mag[1] <= {16'h0000, 16'h0200, 16'h0000, 16'h0500, 16'h0000, 16'h0000};
		send('0);
		chk_rd(8'h3A, 16'h1303);
		chk_rd(8'h38, 16'h0000);
		chk_rd(8'h3E, 16'h0500);
		chk_rd(8'h46, 16'h0022);
		chk_rd(8'h34, 16'h0006);
		// Latched flags wiped by the clear command
		i_host_model.wr(8'h30, 16'h0082);
		i_host_model.wr(8'h36, 16'h0010);
		chk_rd(8'h34, 16'h0000);
		finish_test();
	end
endmodule // tb_spectral_alarm_regs
